//--- touch_qual_pkg.sv
// Constants shared by the touch qualification block
package touch_qual_pkg;
  localparam int CLK_PERIOD_NS = 25;
  localparam int MS_NS = 1000000;
  localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
  localparam logic [9:0] WDOG_MS = 10'h1F4;
  localparam logic [7:0] MAX_CYCLE_MS = 8'hFE;
  localparam logic [6:0] CAL_CYCLES = 7'h40;
  localparam int N_NODES = 12;
  localparam int N_OBJ = 3;
  localparam int KEY_OBJ = 2;
  localparam logic [3:0] N_NODES_IDX = 4'hC;

  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_NODE_EN = 4'h1;
  localparam logic [3:0] ADDR_THR = 4'h2;
  localparam logic [3:0] ADDR_LIMIT = 4'h3;
  localparam logic [3:0] ADDR_HOLD = 4'h4;
  localparam logic [3:0] ADDR_IDLE_INT = 4'h5;
  localparam logic [3:0] ADDR_ACTV_INT = 4'h6;
  localparam logic [3:0] ADDR_A2I = 4'h7;
  localparam logic [3:0] ADDR_GROUP = 4'h8;
  localparam logic [3:0] ADDR_GRIP = 4'h9;
  localparam logic [3:0] ADDR_MAXT = 4'hA;
  localparam logic [3:0] ADDR_RANGE = 4'hB;
  localparam logic [3:0] ADDR_STATUS = 4'hC;
  localparam logic [3:0] ADDR_REPORT = 4'hD;
  localparam logic [3:0] ADDR_MSG = 4'hE;

  localparam int CTRL_RECAL = 0;
  localparam int CTRL_NOISE = 1;
  localparam int CTRL_RANGE = 2;
  localparam int CTRL_KEYSUP = 3;

  localparam logic [11:0] NODE_EN_RST = 12'hFFF;
  localparam logic [10:0] THR_RST = 11'h040;
  localparam logic [3:0] LIMIT_RST = 4'h4;
  localparam logic [7:0] HOLD_RST = 8'h00;
  localparam logic [7:0] IDLE_INT_RST = 8'h20;
  localparam logic [7:0] ACTV_INT_RST = 8'h0A;
  localparam logic [15:0] A2I_RST = 16'h01F4;
  localparam logic [5:0] GROUP_RST = 6'h00;
  localparam logic [7:0] GRIP_RST = 8'h00;
  localparam logic [5:0] MAXT_RST = 6'h24;
  localparam logic [10:0] RANGE_RST = 11'h7FF;

  localparam logic [1:0] MSG_NONE = 2'h0;
  localparam logic [1:0] MSG_CAL_START = 2'h1;
  localparam logic [1:0] MSG_CAL_DONE = 2'h2;

  typedef enum {CYC_BURST, CYC_SLEEP} cyc_state_t;
endpackage

//--- cycle_timer.sv
// Burst and sleep cycle timer with active to idle fallback
module cycle_timer
  import touch_qual_pkg::*;
#(
  parameter int MS_TICK_CYCLES = MS_CYCLES
)
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [7:0] idle_int,
  input wire logic [7:0] actv_int,
  input wire logic [15:0] a2i_to,
  input wire logic touch_present,
  input wire logic acq_done,
  output logic burst_active,
  output logic active_mode,
  output logic cycle_done,
  output logic ms_tick
);
  logic [31:0] div_q;
  cyc_state_t state_q;
  logic [7:0] elapsed_q;
  logic [15:0] quiet_q;
  logic active_q;
  logic [7:0] iv;

  function automatic logic [7:0] clamp_iv(input logic [7:0] v);
    if (v == 8'h00)
      clamp_iv = 8'h01;
    else if (v > MAX_CYCLE_MS)
      clamp_iv = MAX_CYCLE_MS;
    else
      clamp_iv = v;
  endfunction

  assign ms_tick = (div_q == 32'(MS_TICK_CYCLES - 1));
  assign iv = clamp_iv(active_q ? actv_int : idle_int);
  assign cycle_done = (state_q == CYC_SLEEP) && (elapsed_q >= iv);
  assign burst_active = (state_q == CYC_BURST);
  assign active_mode = active_q;

  // Millisecond divider
  always_ff @(posedge sys_clk or posedge reset)
    if (reset)
      div_q <= 32'h0000_0000;
    else if (ms_tick)
      div_q <= 32'h0000_0000;
    else
      div_q <= div_q + 32'h0000_0001;

  // Time since start of cycle
  always_ff @(posedge sys_clk or posedge reset)
    if (reset)
      elapsed_q <= 8'h00;
    else if (cycle_done)
      elapsed_q <= 8'h00;
    else if (ms_tick && elapsed_q != 8'hFF)
      elapsed_q <= elapsed_q + 8'h01;

  // Burst then sleep
  always_ff @(posedge sys_clk or posedge reset)
    if (reset)
      state_q <= CYC_BURST;
    else
      case (state_q)
        CYC_BURST:
          if (acq_done)
            state_q <= CYC_SLEEP;
        CYC_SLEEP:
          if (cycle_done)
            state_q <= CYC_BURST;
        default:
          state_q <= CYC_BURST;
      endcase

  // Active mode, dropped after quiet timeout
  always_ff @(posedge sys_clk or posedge reset)
    if (reset)
    begin
      active_q <= 1'b0;
      quiet_q <= 16'h0000;
    end
    else if (touch_present)
    begin
      active_q <= 1'b1;
      quiet_q <= 16'h0000;
    end
    else if (active_q && ms_tick)
    begin
      if (quiet_q + 16'h0001 >= a2i_to)
      begin
        active_q <= 1'b0;
        quiet_q <= 16'h0000;
      end
      else
        quiet_q <= quiet_q + 16'h0001;
    end
endmodule

//--- touch_qualify_and_calibrate.sv
// Touch qualification, suppression, calibration and watchdog
// Notes on behaviour
// - Watchdog always on, fixed 500 ms, just under twice the 254 ms longest cycle.
// - Calibrate at power-up and node enable; otherwise only on listed triggers or watchdog expiry.
// - Recalibrate when an enabled node stays in detect beyond hold time.
// - Recalibrate on anti-touch delta at threshold while no touch exists.
// - Host recalibrate command or key configuration change recalibrates, any time.
// - One message at calibration start, one at calibration end.
// - Calibration is global; all nodes together.
// - Cycles of burst then sleep; length from idle or active interval.
// - Configurable timeout moves active mode to idle mode.
// - In a suppression group only the first-touched object reports.
// - Group blocks new detections until detected object is released.
// - An object may belong to several groups, each applied independently.
// - Key array internal suppression: one key blocks other keys.
// - Touch already in detect survives enabling suppression until release.
// - Integration counter increments on each above-threshold acquisition.
// - Sensor touched only once counter reaches configured limit.
// - Counter cleared on any acquisition not above threshold.
// - Noise suppression active from noise input pin or host indication.
// - With range rejection on, out-of-limit samples are discarded.
// - Border zone touches suppressed per touchscreen; centre still reported.
// - All touches of a screen suppressed when count exceeds maximum.
//
// Our own choices: the register offsets and the strobed register port.
module touch_qualify_and_calibrate
  import touch_qual_pkg::*;
#(
  parameter int MS_TICK_CYCLES = MS_CYCLES
)
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic acq_valid,
  input wire logic [3:0] acq_node,
  input wire logic signed [11:0] acq_delta,
  input wire logic acq_done,
  input wire logic noise_source_input,
  output logic burst_active,
  output logic cal_active,
  output logic noise_suppress_active,
  output logic [11:0] touch_report,
  output logic msg_valid,
  output logic [1:0] msg_code,
  output logic wdog_expire
);
  logic host_noise_q, range_en_q, key_supp_q;
  logic [11:0] node_en_q;
  logic [10:0] thr_q;
  logic [3:0] limit_q;
  logic [7:0] hold_time_q, idle_int_q, actv_int_q;
  logic [15:0] a2i_q;
  logic [5:0] grp_q;
  logic [7:0] grip_q;
  logic [5:0] max_q;
  logic [10:0] range_q;
  logic [15:0] rd_d;
  logic [3:0] integ_q [N_NODES];
  logic [7:0] hold_q [N_NODES];
  logic [11:0] detect_q, report_q, report_d, touch_d, qual;
  logic cal_req_q, cal_active_q, cal_start, cal_end, trig;
  logic [6:0] cal_cnt_q;
  logic [9:0] wdog_cnt_q;
  logic noise_q, active_mode, cycle_done, ms_tick, hold_trip;
  logic recal_cmd, cfg_change, en_rise;
  logic samp_ok, samp_use, range_bad, above, anti_trip;
  logic [11:0] abs_delta, neg_thr;
  logic [3:0] integ_cur, integ_inc;

  function automatic logic obj_any(input logic [11:0] v, input int o);
    obj_any = |v[o*4 +: 4];
  endfunction

  function automatic logic [2:0] popcnt4(input logic [3:0] v);
    popcnt4 = {2'b00, v[0]} + {2'b00, v[1]} + {2'b00, v[2]} + {2'b00, v[3]};
  endfunction

  // Register writes
  always_ff @(posedge sys_clk or posedge reset)
    if (reset)
    begin
      host_noise_q <= 1'b0;
      range_en_q <= 1'b0;
      key_supp_q <= 1'b0;
      node_en_q <= NODE_EN_RST;
      thr_q <= THR_RST;
      limit_q <= LIMIT_RST;
      hold_time_q <= HOLD_RST;
      idle_int_q <= IDLE_INT_RST;
      actv_int_q <= ACTV_INT_RST;
      a2i_q <= A2I_RST;
      grp_q <= GROUP_RST;
      grip_q <= GRIP_RST;
      max_q <= MAXT_RST;
      range_q <= RANGE_RST;
    end
    else if (reg_wr)
      case (reg_addr)
        ADDR_CTRL:
        begin
          host_noise_q <= reg_wdata[CTRL_NOISE];
          range_en_q <= reg_wdata[CTRL_RANGE];
          key_supp_q <= reg_wdata[CTRL_KEYSUP];
        end
        ADDR_NODE_EN: node_en_q <= reg_wdata[11:0];
        ADDR_THR: thr_q <= reg_wdata[10:0];
        ADDR_LIMIT: limit_q <= reg_wdata[3:0];
        ADDR_HOLD: hold_time_q <= reg_wdata[7:0];
        ADDR_IDLE_INT: idle_int_q <= reg_wdata[7:0];
        ADDR_ACTV_INT: actv_int_q <= reg_wdata[7:0];
        ADDR_A2I: a2i_q <= reg_wdata;
        ADDR_GROUP: grp_q <= reg_wdata[5:0];
        ADDR_GRIP: grip_q <= reg_wdata[7:0];
        ADDR_MAXT: max_q <= reg_wdata[5:0];
        ADDR_RANGE: range_q <= reg_wdata[10:0];
        default: ;
      endcase

  // Read mux; unmapped reads return zero
  always_comb
  begin
    case (reg_addr)
      ADDR_CTRL: rd_d = {12'h000, key_supp_q, range_en_q, host_noise_q, 1'b0};
      ADDR_NODE_EN: rd_d = {4'h0, node_en_q};
      ADDR_THR: rd_d = {5'h00, thr_q};
      ADDR_LIMIT: rd_d = {12'h000, limit_q};
      ADDR_HOLD: rd_d = {8'h00, hold_time_q};
      ADDR_IDLE_INT: rd_d = {8'h00, idle_int_q};
      ADDR_ACTV_INT: rd_d = {8'h00, actv_int_q};
      ADDR_A2I: rd_d = a2i_q;
      ADDR_GROUP: rd_d = {10'h000, grp_q};
      ADDR_GRIP: rd_d = {8'h00, grip_q};
      ADDR_MAXT: rd_d = {10'h000, max_q};
      ADDR_RANGE: rd_d = {5'h00, range_q};
      ADDR_STATUS: rd_d = {11'h000, cal_req_q, burst_active, noise_q, cal_active_q, active_mode};
      ADDR_REPORT: rd_d = {4'h0, touch_report};
      ADDR_MSG: rd_d = {14'h0000, msg_code};
      default: rd_d = 16'h0000;
    endcase
  end

  always_ff @(posedge sys_clk or posedge reset)
    if (reset)
      reg_rdata <= 16'h0000;
    else if (reg_rd)
      reg_rdata <= rd_d;
    else
      reg_rdata <= 16'h0000;

  // Recalibration triggers from the host side
  assign recal_cmd = reg_wr && reg_addr == ADDR_CTRL && reg_wdata[CTRL_RECAL];
  assign cfg_change = reg_wr && (reg_addr == ADDR_THR || reg_addr == ADDR_LIMIT);
  assign en_rise = reg_wr && reg_addr == ADDR_NODE_EN && |(reg_wdata[11:0] & ~node_en_q);

  // Noise suppression request
  always_ff @(posedge sys_clk or posedge reset)
    if (reset)
      noise_q <= 1'b0;
    else
      noise_q <= noise_source_input | host_noise_q;
  assign noise_suppress_active = noise_q;

  // Sample qualification
  assign samp_ok = acq_valid && !cal_active_q && acq_node < N_NODES_IDX && node_en_q[acq_node];
  assign abs_delta = acq_delta[11] ? 12'(-acq_delta) : acq_delta;
  assign range_bad = range_en_q && abs_delta > {1'b0, range_q};
  assign samp_use = samp_ok && !range_bad;
  assign above = acq_delta > $signed({1'b0, thr_q});
  assign neg_thr = 12'(-{1'b0, thr_q});
  assign anti_trip = samp_use && acq_delta <= $signed(neg_thr)
                     && detect_q == 12'h000 && report_q == 12'h000;
  assign integ_cur = integ_q[acq_node];
  assign integ_inc = (integ_cur >= limit_q) ? integ_cur : integ_cur + 4'h1;

  // Detection integrator
  always_ff @(posedge sys_clk or posedge reset)
    if (reset)
    begin
      for (int n = 0; n < N_NODES; n++)
        integ_q[n] <= 4'h0;
      detect_q <= 12'h000;
    end
    else if (cal_active_q)
    begin
      for (int n = 0; n < N_NODES; n++)
        integ_q[n] <= 4'h0;
      detect_q <= 12'h000;
    end
    else if (samp_use)
    begin
      if (above)
      begin
        integ_q[acq_node] <= integ_inc;
        detect_q[acq_node] <= integ_inc >= limit_q;
      end
      else
      begin
        integ_q[acq_node] <= 4'h0;
        detect_q[acq_node] <= 1'b0;
      end
    end

  // Detect hold counters
  always_ff @(posedge sys_clk or posedge reset)
    if (reset)
      for (int n = 0; n < N_NODES; n++)
        hold_q[n] <= 8'h00;
    else if (cal_active_q)
      for (int n = 0; n < N_NODES; n++)
        hold_q[n] <= 8'h00;
    else if (acq_done)
      for (int n = 0; n < N_NODES; n++)
        if (detect_q[n] && node_en_q[n])
          hold_q[n] <= (hold_q[n] == 8'hFF) ? 8'hFF : hold_q[n] + 8'h01;
        else
          hold_q[n] <= 8'h00;

  always_comb
  begin
    hold_trip = 1'b0;
    for (int n = 0; n < N_NODES; n++)
      if (hold_time_q != 8'h00 && detect_q[n] && node_en_q[n] && hold_q[n] >= hold_time_q)
        hold_trip = 1'b1;
  end

  // Group and internal suppression, grip, max touch
  always_comb
  begin
    logic blocked;
    int o;
    blocked = 1'b0;
    o = 0;
    qual = detect_q & node_en_q & ~{4'h0, grip_q};
    report_d = report_q & qual;
    for (int n = 0; n < N_NODES; n++)
      if (qual[n] && !report_d[n])
      begin
        o = n / 4;
        blocked = 1'b0;
        for (int p = 0; p < N_OBJ; p++)
          if (p != o && |(grp_q[o*2 +: 2] & grp_q[p*2 +: 2]) && obj_any(report_d, p))
            blocked = 1'b1;
        if (o == KEY_OBJ && key_supp_q && obj_any(report_d, KEY_OBJ))
          blocked = 1'b1;
        if (!blocked)
          report_d[n] = 1'b1;
      end
    touch_d = report_d;
    if (popcnt4(report_d[3:0]) > max_q[2:0])
      touch_d[3:0] = 4'h0;
    if (popcnt4(report_d[7:4]) > max_q[5:3])
      touch_d[7:4] = 4'h0;
  end

  // Reported touches, updated at end of burst
  always_ff @(posedge sys_clk or posedge reset)
    if (reset)
    begin
      report_q <= 12'h000;
      touch_report <= 12'h000;
    end
    else if (cal_active_q)
    begin
      report_q <= 12'h000;
      touch_report <= 12'h000;
    end
    else if (acq_done)
    begin
      report_q <= report_d;
      touch_report <= touch_d;
    end

  // Calibration sequencer
  assign trig = recal_cmd | cfg_change | en_rise | (hold_trip & acq_done)
                | anti_trip | wdog_expire;
  assign cal_start = cal_req_q && !cal_active_q;
  assign cal_end = cal_active_q && cal_cnt_q == CAL_CYCLES - 7'h01;

  always_ff @(posedge sys_clk or posedge reset)
    if (reset)
      cal_req_q <= 1'b1;
    else
      cal_req_q <= trig | (cal_req_q & ~cal_start);

  always_ff @(posedge sys_clk or posedge reset)
    if (reset)
    begin
      cal_active_q <= 1'b0;
      cal_cnt_q <= 7'h00;
    end
    else if (cal_start)
    begin
      cal_active_q <= 1'b1;
      cal_cnt_q <= 7'h00;
    end
    else if (cal_end)
      cal_active_q <= 1'b0;
    else if (cal_active_q)
      cal_cnt_q <= cal_cnt_q + 7'h01;
  assign cal_active = cal_active_q;

  // Status messages
  always_ff @(posedge sys_clk or posedge reset)
    if (reset)
    begin
      msg_valid <= 1'b0;
      msg_code <= MSG_NONE;
    end
    else
    begin
      msg_valid <= cal_start | cal_end;
      if (cal_start)
        msg_code <= MSG_CAL_START;
      else if (cal_end)
        msg_code <= MSG_CAL_DONE;
    end

  // Watchdog, restarted each completed cycle
  always_ff @(posedge sys_clk or posedge reset)
    if (reset)
    begin
      wdog_cnt_q <= 10'h000;
      wdog_expire <= 1'b0;
    end
    else
    begin
      wdog_expire <= 1'b0;
      if (cycle_done)
        wdog_cnt_q <= 10'h000;
      else if (ms_tick)
      begin
        if (wdog_cnt_q == WDOG_MS - 10'h001)
        begin
          wdog_cnt_q <= 10'h000;
          wdog_expire <= 1'b1;
        end
        else
          wdog_cnt_q <= wdog_cnt_q + 10'h001;
      end
    end

  cycle_timer #(
    .MS_TICK_CYCLES(MS_TICK_CYCLES)
  ) u_cycle (
    .sys_clk(sys_clk),
    .reset(reset),
    .idle_int(idle_int_q),
    .actv_int(actv_int_q),
    .a2i_to(a2i_q),
    .touch_present(|report_q),
    .acq_done(acq_done),
    .burst_active(burst_active),
    .active_mode(active_mode),
    .cycle_done(cycle_done),
    .ms_tick(ms_tick)
  );

  // Checks
  chk_cal_start_msg: assert property (@(posedge sys_clk) disable iff (reset)
    cal_start |=> msg_valid && msg_code == MSG_CAL_START)
    else $error("no start message");
  chk_cal_done_msg: assert property (@(posedge sys_clk) disable iff (reset)
    $fell(cal_active_q) |-> msg_valid && msg_code == MSG_CAL_DONE)
    else $error("no done message");
  chk_cal_global: assert property (@(posedge sys_clk) disable iff (reset)
    cal_start |=> ##1 touch_report == 12'h000 && detect_q == 12'h000)
    else $error("calibration not global");
  chk_integ_clear: assert property (@(posedge sys_clk) disable iff (reset)
    samp_use && !above && acq_node == 4'h0 |=> integ_q[0] == 4'h0 && !detect_q[0])
    else $error("integrator not cleared");
  chk_integ_step: assert property (@(posedge sys_clk) disable iff (reset)
    samp_use && above && acq_node == 4'h0 && integ_q[0] < limit_q
    |=> integ_q[0] == $past(integ_q[0]) + 4'h1)
    else $error("integrator not stepped");
  chk_detect_limit: assert property (@(posedge sys_clk) disable iff (reset)
    $rose(detect_q[0]) |-> integ_q[0] >= limit_q)
    else $error("detect before limit");
  chk_grip_border: assert property (@(posedge sys_clk) disable iff (reset)
    $past(acq_done) && !$past(cal_active_q) && $stable(grip_q)
    |-> (touch_report[7:0] & grip_q) == 8'h00)
    else $error("border touch reported");
  chk_max_touch: assert property (@(posedge sys_clk) disable iff (reset)
    $past(acq_done) && $stable(max_q) |-> popcnt4(touch_report[3:0]) <= max_q[2:0]
    && popcnt4(touch_report[7:4]) <= max_q[5:3])
    else $error("max touch exceeded");
  chk_wdog_restart: assert property (@(posedge sys_clk) disable iff (reset)
    cycle_done |=> wdog_cnt_q == 10'h000 && !wdog_expire)
    else $error("watchdog not restarted");
  chk_noise_follow: assert property (@(posedge sys_clk) disable iff (reset)
    noise_source_input |=> noise_suppress_active)
    else $error("noise suppression missed");
endmodule

//--- acq_src.sv
// Acquisition front end model feeding node samples
module acq_src
  import touch_qual_pkg::*;
(
  input wire logic sys_clk,
  output logic acq_valid,
  output logic [3:0] acq_node,
  output logic signed [11:0] acq_delta,
  output logic acq_done
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    acq_valid = 1'b0;
    acq_node = 4'h0;
    acq_delta = 12'h000;
    acq_done = 1'b0;
  end
  // Samples of one node, then idle lines carry no stale value
  task automatic send(input logic [3:0] n, input logic [11:0] d, input int c);
    repeat (c)
    begin
      @(posedge sys_clk);
      acq_valid <= 1'b1;
      acq_node <= n;
      acq_delta <= d;
    end
    @(posedge sys_clk);
    acq_valid <= 1'b0;
    acq_node <= ~n;
    acq_delta <= ~d;
  endtask
  // End of burst pulse
  task automatic done();
    @(posedge sys_clk);
    acq_done <= 1'b1;
    @(posedge sys_clk);
    acq_done <= 1'b0;
  endtask
endmodule

//--- touch_qualify_and_calibrate_tb.sv
// Self-checking bench for the touch qualification block
module touch_qualify_and_calibrate_tb
  import touch_qual_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TICK = 4;
  typedef struct {logic [3:0] n; logic [11:0] d; logic [11:0] r;} row_t;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic noise_source_input = 1'b0;
  logic [15:0] reg_rdata;
  logic [15:0] rv;
  logic acq_valid;
  logic acq_done;
  logic [3:0] acq_node;
  logic signed [11:0] acq_delta;
  logic burst_active;
  logic cal_active;
  logic noise_suppress_active;
  logic msg_valid;
  logic wdog_expire;
  logic [11:0] touch_report;
  logic [1:0] msg_code;
  int err_count = 0;
  int compares = 0;
  int starts = 0;
  int dones = 0;
  int wdogs = 0;
  int want = 0;
  int k;
  row_t rows [11] = '{
    '{4'h0, 12'h050, 12'h000},
    '{4'h0, 12'h040, 12'h000},
    '{4'h0, 12'h050, 12'h000},
    '{4'h0, 12'h050, 12'h001},
    '{4'h0, 12'h000, 12'h000},
    '{4'h4, 12'h041, 12'h000},
    '{4'h4, 12'h041, 12'h010},
    '{4'h4, 12'h000, 12'h000},
    '{4'hA, 12'h07F, 12'h000},
    '{4'hA, 12'h07F, 12'h400},
    '{4'hA, 12'h000, 12'h000}};

  touch_qualify_and_calibrate #(.MS_TICK_CYCLES(TICK)) DUT (
    .sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .acq_valid(acq_valid),
    .acq_node(acq_node), .acq_delta(acq_delta), .acq_done(acq_done),
    .noise_source_input(noise_source_input), .burst_active(burst_active),
    .cal_active(cal_active), .noise_suppress_active(noise_suppress_active),
    .touch_report(touch_report), .msg_valid(msg_valid), .msg_code(msg_code),
    .wdog_expire(wdog_expire));
  acq_src src (.sys_clk(sys_clk), .acq_valid(acq_valid), .acq_node(acq_node),
    .acq_delta(acq_delta), .acq_done(acq_done));

  initial
  begin
    forever #12.5 sys_clk = ~sys_clk;
  end
  // Message and watchdog pulse counters
  always @(posedge sys_clk)
  begin
    if (msg_valid === 1'b1 && msg_code === MSG_CAL_START)
      starts <= starts + 1;
    if (msg_valid === 1'b1 && msg_code === MSG_CAL_DONE)
      dones <= dones + 1;
    if (wdog_expire === 1'b1)
      wdogs <= wdogs + 1;
  end

  task automatic report_and_stop();
    $display("Compares %0d, mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e)
    begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    rv = reg_rdata;
  endtask
  task automatic rep(input logic [11:0] e);
    src.done();
    @(negedge sys_clk);
    chk("touch_report", {4'h0, e}, {4'h0, touch_report});
  endtask
  // Wait out a calibration, then compare message counts
  task automatic cal_chk(input int add);
    want += add;
    repeat (4) @(negedge sys_clk);
    k = 0;
    while (cal_active !== 1'b0 && k < 200)
    begin
      @(negedge sys_clk);
      k++;
    end
    repeat (3) @(negedge sys_clk);
    chk("cal_starts", want[15:0], starts[15:0]);
    chk("cal_dones", want[15:0], dones[15:0]);
  endtask

  initial
  begin
    #1ms;
    err_count++;
    report_and_stop();
  end

  initial
  begin
    repeat (4) @(posedge sys_clk);
    reset <= 1'b0;
    cal_chk(1);
    wr(ADDR_LIMIT, 16'h0002);
    cal_chk(1);
    foreach (rows[i])
    begin
      src.send(rows[i].n, rows[i].d, 1);
      rep(rows[i].r);
    end
    rd(ADDR_THR);
    chk("thr", 16'h0040, rv);
    wr(4'hF, 16'h1234);
    rd(4'hF);
    chk("unmapped", 16'h0000, rv);
    // Suppression groups
    src.send(4'h0, 12'h050, 2);
    src.send(4'h8, 12'h050, 2);
    rep(12'h101);
    wr(ADDR_GROUP, 16'h0011);
    rep(12'h101);
    src.send(4'h8, 12'h000, 1);
    rep(12'h001);
    src.send(4'h8, 12'h050, 2);
    rep(12'h001);
    src.send(4'h0, 12'h000, 1);
    src.done();
    src.send(4'h8, 12'h050, 1);
    rep(12'h100);
    wr(ADDR_GROUP, 16'h0027);
    src.send(4'h0, 12'h050, 2);
    src.send(4'h4, 12'h050, 2);
    rep(12'h110);
    src.send(4'h0, 12'h000, 1);
    src.send(4'h4, 12'h000, 1);
    src.send(4'h8, 12'h000, 1);
    rep(12'h000);
    wr(ADDR_GROUP, 16'h0000);
    // Key array internal suppression
    wr(ADDR_CTRL, 16'h0008);
    src.send(4'h8, 12'h050, 2);
    src.send(4'h9, 12'h050, 2);
    rep(12'h100);
    src.send(4'h8, 12'h000, 1);
    src.send(4'h9, 12'h000, 1);
    rep(12'h000);
    // Range rejection
    wr(ADDR_RANGE, 16'h0100);
    wr(ADDR_CTRL, 16'h0004);
    src.send(4'h1, 12'h200, 2);
    rep(12'h000);
    src.send(4'h1, 12'h080, 2);
    rep(12'h002);
    src.send(4'h1, 12'h000, 1);
    rep(12'h000);
    wr(ADDR_CTRL, 16'h0000);
    // Border zone and maximum touches
    wr(ADDR_GRIP, 16'h0001);
    src.send(4'h0, 12'h050, 2);
    src.send(4'h2, 12'h050, 2);
    rep(12'h004);
    wr(ADDR_MAXT, 16'h0021);
    src.send(4'h3, 12'h050, 2);
    rep(12'h000);
    wr(ADDR_MAXT, 16'h0024);
    rep(12'h00C);
    src.send(4'h0, 12'h000, 1);
    src.send(4'h2, 12'h000, 1);
    src.send(4'h3, 12'h000, 1);
    rep(12'h000);
    wr(ADDR_GRIP, 16'h0000);
    // Calibration triggers
    src.send(4'h1, 12'hFC0, 1);
    cal_chk(1);
    wr(ADDR_CTRL, 16'h0001);
    repeat (3) @(posedge sys_clk);
    rd(ADDR_STATUS);
    chk("status_cal", 16'h0002, rv & 16'h0002);
    cal_chk(1);
    rd(ADDR_CTRL);
    chk("ctrl", 16'h0000, rv);
    wr(ADDR_NODE_EN, 16'h0FFE);
    cal_chk(0);
    wr(ADDR_NODE_EN, 16'h0FFF);
    cal_chk(1);
    wr(ADDR_HOLD, 16'h0002);
    src.send(4'h5, 12'h050, 2);
    repeat (3) src.done();
    cal_chk(1);
    src.send(4'h5, 12'h000, 1);
    wr(ADDR_HOLD, 16'h0000);
    // Noise indication
    @(posedge sys_clk);
    noise_source_input <= 1'b1;
    repeat (2) @(negedge sys_clk);
    chk("noise_pin", 16'h0001, {15'h0, noise_suppress_active});
    @(posedge sys_clk);
    noise_source_input <= 1'b0;
    wr(ADDR_CTRL, 16'h0002);
    repeat (2) @(negedge sys_clk);
    chk("noise_host", 16'h0001, {15'h0, noise_suppress_active});
    wr(ADDR_CTRL, 16'h0000);
    repeat (2) @(negedge sys_clk);
    chk("noise_off", 16'h0000, {15'h0, noise_suppress_active});
    // Burst and sleep cycling, active mode
    wr(ADDR_IDLE_INT, 16'h0002);
    wr(ADDR_A2I, 16'h0003);
    src.done();
    @(negedge sys_clk);
    chk("sleep", 16'h0000, {15'h0, burst_active});
    k = 0;
    while (burst_active !== 1'b1 && k < 2 * TICK + 4)
    begin
      @(negedge sys_clk);
      k++;
    end
    chk("burst_again", 16'h0001, {15'h0, burst_active});
    src.send(4'h0, 12'h050, 2);
    rep(12'h001);
    rd(ADDR_STATUS);
    chk("active", 16'h0001, rv & 16'h0001);
    src.send(4'h0, 12'h000, 1);
    rep(12'h000);
    repeat (40) @(negedge sys_clk);
    rd(ADDR_STATUS);
    chk("idle", 16'h0000, rv & 16'h0001);
    // Watchdog
    repeat (24)
    begin
      src.done();
      repeat (100) @(negedge sys_clk);
    end
    chk("wdog_quiet", 16'h0000, wdogs[15:0]);
    k = 0;
    while (wdogs == 0 && k < 2600)
    begin
      @(negedge sys_clk);
      k++;
    end
    chk("wdog_time", 16'h0001, {15'h0, k > 1800 && k < 2000});
    cal_chk(1);
    // Reset in mid-run
    @(posedge sys_clk);
    reset <= 1'b1;
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    cal_chk(1);
    rd(ADDR_LIMIT);
    chk("limit", 16'h0004, rv);
    report_and_stop();
  end
endmodule
